// ### hdl/gw_lead_ctrl.sv
// Gateway-mode control-lead sequencer with APB registers
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
module gw_lead_ctrl #(
    parameter int TICK_CYC = gw_lead_pkg::TICK_CYC
) (
    input wire logic i_mclk,                              // 40 MHz clock
    input wire logic i_rst_b,                             // Async reset, active low
    input wire logic [gw_lead_pkg::MODE_W-1:0] i_mode,    // Static mode strap
    input wire logic i_dsr,                               // DSR lead from gateway
    input wire logic i_dcd,                               // DCD lead from gateway
    input wire logic i_out_call,                          // Caller rings for outbound
    input wire logic i_cr_seen,                           // Autobaud CR received
    input wire logic i_hot_answer,                        // Hotline callee answered
    input wire logic i_hot_noans,                         // Hotline callee busy/no answer
    input wire logic i_local_release,                     // Switch side releases call
    output logic o_dtr,                                   // DTR lead to gateway
    output logic o_answer,                                // Answer caller, pulse
    output logic o_out_busy,                              // Busy for outbound calls
    output logic o_prompt_en,                             // Prompts and menus allowed
    output logic o_link_up,                               // Transparent data link
    output logic o_hot_dial,                              // Place Hotline call, pulse
    output logic [gw_lead_pkg::BAUD_W-1:0] o_hot_baud,    // Hotline bit rate code
    output logic o_hot_autobaud,                          // Hotline uses autobaud
    output logic o_call_drop,                             // Call dropped, pulse
    input wire logic psel,                                // APB select
    input wire logic penable,                             // APB enable
    input wire logic pwrite,                              // APB write
    input wire logic [gw_lead_pkg::ADDR_W-1:0] paddr,     // APB address
    input wire logic [31:0] pwdata,                       // APB write data
    output logic [31:0] prdata,                           // APB read data
    output logic pready,                                  // APB ready
    output logic pslverr                                  // APB error
);
    import gw_lead_pkg::*;

    // ****************************************
    // Reset release and state
    // ****************************************
    logic [1:0] rst_sync_ff;
    logic rst_n;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];
    typedef enum logic [2:0] {
        ST_IDLE, ST_OUT_WAIT, ST_IN_AB, ST_HOT_DIAL, ST_HOT_WAIT, ST_CONNECTED, ST_DISC
    } state_t;
    typedef struct packed {
        logic [1:0][MODE_W-1:0] mode_sync;
        logic [1:0] dcd_sync;
        logic [1:0] dsr_sync;
        logic dcd_prev;
        logic dsr_prev;
        state_t state;
        logic inbound;
        logic dtr;
        logic busy;
        logic answer;
        logic drop;
        logic hot_dial;
        logic en;
        logic auto_baud_setting;
        logic [BAUD_W-1:0] baud;
        logic [BAUD_W-1:0] hrate;
        logic [31:0] prdata;
    } st_t;
    st_t st_ff;
    st_t nxt_st;
    interval_tmr_if tmr_bus ();
    interval_tmr #(
        .TICK_CYC(TICK_CYC)
    ) u_tmr (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .tmr(tmr_bus.tmr)
    );
    logic [MODE_W-1:0] mode;
    logic gw;
    logic hotline;
    logic dtr_idle_on;
    logic dcd_on;
    logic dcd_rise;
    logic dcd_fall;
    logic dsr_fall;
    logic apb_setup;
    logic apb_wr;
    logic hit_ctrl;
    logic hit_stat;
    logic [31:0] stat_word;
    assign mode = st_ff.mode_sync[1];
    assign gw = st_ff.en && (mode >= MODE_GW_LO) && (mode <= MODE_GW_HI);
    assign hotline = (mode == MODE_HOT_DTR_OFF) || (mode == MODE_HOT_DTR_ON);
    assign dtr_idle_on = (mode == MODE_PLAIN_DTR_ON) || (mode == MODE_HOT_DTR_ON);
    // No RI input exists; calls start only from DCD or the switch side
    assign dcd_on = st_ff.dcd_sync[1];
    assign dcd_rise = dcd_on && !st_ff.dcd_prev;
    assign dcd_fall = !dcd_on && st_ff.dcd_prev;
    assign dsr_fall = !st_ff.dsr_sync[1] && st_ff.dsr_prev;
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign hit_ctrl = (paddr == REG_CTRL_OFS);
    assign hit_stat = (paddr == REG_STAT_OFS);
    always_comb begin
        stat_word = 32'h0;
        stat_word[STAT_DTR_BIT] = st_ff.dtr;
        stat_word[STAT_DSR_BIT] = st_ff.dsr_sync[1];
        stat_word[STAT_DCD_BIT] = dcd_on;
        stat_word[STAT_BUSY_BIT] = st_ff.busy;
        stat_word[STAT_PROMPT_BIT] = o_prompt_en;
        stat_word[STAT_LINK_BIT] = o_link_up;
        stat_word[STAT_STATE_LSB +: 3] = st_ff.state;
    end
    // ****************************************
    // Sequencer and register file
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        tmr_bus.load = 1'b0;
        tmr_bus.load_val = DTR_DROP_TICKS;
        nxt_st.mode_sync = {st_ff.mode_sync[0], i_mode};
        nxt_st.dcd_sync = {st_ff.dcd_sync[0], i_dcd};
        nxt_st.dsr_sync = {st_ff.dsr_sync[0], i_dsr};
        nxt_st.dcd_prev = dcd_on;
        nxt_st.dsr_prev = st_ff.dsr_sync[1];
        nxt_st.answer = 1'b0;
        nxt_st.drop = 1'b0;
        nxt_st.hot_dial = 1'b0;
        if (!gw) begin
            nxt_st.state = ST_IDLE;
            nxt_st.dtr = 1'b0;
            nxt_st.busy = 1'b0;
            nxt_st.inbound = 1'b0;
        end else begin
            unique case (st_ff.state)
                ST_IDLE: begin
                    nxt_st.dtr = dtr_idle_on;
                    nxt_st.busy = 1'b0;
                    nxt_st.inbound = 1'b0;
                    if (dcd_rise && hotline) begin
                        nxt_st.state = ST_HOT_DIAL;
                        nxt_st.hot_dial = 1'b1;
                        nxt_st.dtr = 1'b1;
                        nxt_st.busy = 1'b1;
                        nxt_st.inbound = 1'b1;
                    end else if (dcd_rise) begin
                        nxt_st.state = ST_IN_AB;
                        nxt_st.dtr = 1'b1;
                        nxt_st.busy = 1'b1;
                        nxt_st.inbound = 1'b1;
                    end else if (i_out_call) begin
                        nxt_st.state = ST_OUT_WAIT;
                        nxt_st.answer = 1'b1;
                        nxt_st.dtr = 1'b1;
                        nxt_st.busy = 1'b1;
                        tmr_bus.load = 1'b1;
                        tmr_bus.load_val = CARRIER_TICKS;
                    end
                end
                ST_OUT_WAIT: begin
                    if (i_local_release) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.drop = 1'b1;
                        nxt_st.dtr = dtr_idle_on;
                    end else if (dcd_on) begin
                        nxt_st.state = ST_CONNECTED;
                    end else if (tmr_bus.expired && !dtr_idle_on) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.drop = 1'b1;
                        nxt_st.dtr = 1'b0;
                    end
                end
                ST_IN_AB: begin
                    if (!dcd_on || i_local_release) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.drop = 1'b1;
                        nxt_st.dtr = dtr_idle_on;
                    end else if (i_cr_seen) begin
                        nxt_st.state = ST_CONNECTED;
                    end
                end
                ST_HOT_DIAL: begin
                    if (!dcd_on) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.drop = 1'b1;
                        nxt_st.dtr = dtr_idle_on;
                    end else if (i_hot_answer) begin
                        nxt_st.state = ST_CONNECTED;
                    end else if (i_hot_noans) begin
                        nxt_st.state = ST_HOT_WAIT;
                        tmr_bus.load = 1'b1;
                        tmr_bus.load_val = HOT_RETRY_TICKS;
                    end
                end
                ST_HOT_WAIT: begin
                    if (!dcd_on) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.drop = 1'b1;
                        nxt_st.dtr = dtr_idle_on;
                    end else if (tmr_bus.expired) begin
                        nxt_st.state = ST_HOT_DIAL;
                        nxt_st.hot_dial = 1'b1;
                    end
                end
                ST_CONNECTED: begin
                    if (dsr_fall || dcd_fall || i_local_release) begin
                        nxt_st.drop = 1'b1;
                        nxt_st.dtr = 1'b0;
                        nxt_st.busy = 1'b0;
                        if (dtr_idle_on) begin
                            nxt_st.state = ST_DISC;
                            tmr_bus.load = 1'b1;
                            tmr_bus.load_val = DTR_DROP_TICKS;
                        end else begin
                            nxt_st.state = ST_IDLE;
                        end
                    end
                end
                ST_DISC: begin
                    nxt_st.dtr = 1'b0;
                    if (tmr_bus.expired) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.dtr = 1'b1;
                    end
                end
            endcase
        end
        if (apb_wr && hit_ctrl) begin
            nxt_st.en = pwdata[CTRL_EN_BIT];
            nxt_st.auto_baud_setting = pwdata[CTRL_AUTO_BAUD_SETTING_BIT];
            nxt_st.baud = pwdata[CTRL_BAUD_LSB +: BAUD_W];
            nxt_st.hrate = pwdata[CTRL_HRATE_LSB +: BAUD_W];
        end
        if (apb_setup) begin
            nxt_st.prdata = 32'h0;
            if (hit_ctrl) begin
                nxt_st.prdata[CTRL_EN_BIT] = st_ff.en;
                nxt_st.prdata[CTRL_AUTO_BAUD_SETTING_BIT] = st_ff.auto_baud_setting;
                nxt_st.prdata[CTRL_BAUD_LSB +: BAUD_W] = st_ff.baud;
                nxt_st.prdata[CTRL_HRATE_LSB +: BAUD_W] = st_ff.hrate;
            end else if (hit_stat) begin
                nxt_st.prdata = stat_word;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.state <= ST_IDLE;
            st_ff.en <= CTRL_EN_RST;
            st_ff.auto_baud_setting <= CTRL_AUTO_BAUD_SETTING_RST;
            st_ff.baud <= CTRL_BAUD_RST;
            st_ff.hrate <= CTRL_HRATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_dtr = st_ff.dtr;
    assign o_answer = st_ff.answer;
    assign o_out_busy = st_ff.busy;
    assign o_prompt_en = dcd_on && st_ff.inbound;
    assign o_link_up = (st_ff.state == ST_OUT_WAIT) || (st_ff.state == ST_CONNECTED);
    assign o_hot_dial = st_ff.hot_dial;
    assign o_hot_baud = (mode == MODE_HOT_DTR_ON) ? st_ff.hrate : st_ff.baud;
    assign o_hot_autobaud = (mode == MODE_HOT_DTR_OFF) && st_ff.auto_baud_setting;
    assign o_call_drop = st_ff.drop;
    assign prdata = st_ff.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_ctrl && !hit_stat;

    // ****************************************
    // Assertions
    // ****************************************
    a_gw_only_dtr: assert property (@(posedge i_mclk) disable iff (!rst_n)
        !gw |=> !o_dtr) else $error("DTR driven outside gateway modes");
    a_idle_dtr_off: assert property (@(posedge i_mclk) disable iff (!rst_n)
        gw && !dtr_idle_on && $past(gw && st_ff.state == ST_IDLE) && st_ff.state == ST_IDLE
        && $stable(mode) |-> !o_dtr) else $error("DTR on while idle in mode 4 or 5");
    a_idle_dtr_on: assert property (@(posedge i_mclk) disable iff (!rst_n)
        gw && dtr_idle_on && $past(gw && st_ff.state == ST_IDLE) && st_ff.state == ST_IDLE
        && $stable(mode) |-> o_dtr) else $error("DTR off while idle in mode 6 or 7");
    a_disc_dtr_drop: assert property (@(posedge i_mclk) disable iff (!rst_n)
        st_ff.state == ST_DISC && gw |-> !o_dtr) else $error("DTR on during disconnect");
    a_prompt_gate: assert property (@(posedge i_mclk) disable iff (!rst_n)
        !dcd_on || st_ff.state == ST_OUT_WAIT |-> !o_prompt_en) else $error("Prompt not allowed");
    a_out_answer: assert property (@(posedge i_mclk) disable iff (!rst_n)
        gw && st_ff.state == ST_IDLE && i_out_call && !dcd_rise
        |=> o_answer && o_dtr && o_link_up) else $error("Outbound call not answered");
    a_carrier_timeout: assert property (@(posedge i_mclk) disable iff (!rst_n)
        gw && st_ff.state == ST_OUT_WAIT && tmr_bus.expired && !dcd_on && !dtr_idle_on
        |=> o_call_drop && !o_dtr && st_ff.state == ST_IDLE) else $error("No drop on timeout");
    a_lead_fall_drop: assert property (@(posedge i_mclk) disable iff (!rst_n)
        gw && st_ff.state == ST_CONNECTED && (dsr_fall || dcd_fall)
        |=> o_call_drop ##1 !o_call_drop) else $error("Lead drop did not end call");
    a_inbound_busy: assert property (@(posedge i_mclk) disable iff (!rst_n)
        gw && st_ff.state == ST_IDLE && dcd_rise && !hotline
        |=> o_out_busy && o_dtr && st_ff.state == ST_IN_AB) else $error("Inbound not taken");
    a_hot_start: assert property (@(posedge i_mclk) disable iff (!rst_n)
        gw && st_ff.state == ST_IDLE && dcd_rise && hotline
        |=> o_hot_dial) else $error("Hotline not started on carrier");
    a_hot_rate: assert property (@(posedge i_mclk) disable iff (!rst_n)
        mode == MODE_HOT_DTR_OFF |-> o_hot_baud == st_ff.baud && o_hot_autobaud == st_ff.auto_baud_setting)
        else $error("Mode 5 Hotline rate not from settings");
    c_out_connect: cover property (@(posedge i_mclk) disable iff (!rst_n)
        st_ff.state == ST_OUT_WAIT ##1 st_ff.state == ST_CONNECTED);
    c_in_connect: cover property (@(posedge i_mclk) disable iff (!rst_n)
        st_ff.state == ST_IN_AB ##1 st_ff.state == ST_CONNECTED);
    c_hot_retry: cover property (@(posedge i_mclk) disable iff (!rst_n)
        st_ff.state == ST_HOT_WAIT ##1 st_ff.state == ST_HOT_DIAL);
    c_disc_done: cover property (@(posedge i_mclk) disable iff (!rst_n)
        st_ff.state == ST_DISC ##1 st_ff.state == ST_IDLE);

endmodule : gw_lead_ctrl

// ### hdl/gw_lead_pkg.sv
// Constants shared by the gateway lead sequencer and its interval timer
package gw_lead_pkg;

    // ****************************************
    // Time base
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_PERIOD_US = TICK_PERIOD_NS / 1000;
    localparam int TMR_W = 16;
    localparam int DTR_DROP_MS = 200;
    localparam int CARRIER_WAIT_MS = 35_000;
    localparam int HOT_RETRY_MS = 1000;
    localparam logic [TMR_W-1:0] DTR_DROP_TICKS = TMR_W'(DTR_DROP_MS * 1000 / TICK_PERIOD_US);
    localparam logic [TMR_W-1:0] CARRIER_TICKS = TMR_W'(CARRIER_WAIT_MS * 1000 / TICK_PERIOD_US);
    localparam logic [TMR_W-1:0] HOT_RETRY_TICKS = TMR_W'(HOT_RETRY_MS * 1000 / TICK_PERIOD_US);

    // ****************************************
    // Modes
    // ****************************************
    localparam int MODE_W = 4;
    localparam logic [MODE_W-1:0] MODE_GW_LO = 4'h4;
    localparam logic [MODE_W-1:0] MODE_GW_HI = 4'h7;
    localparam logic [MODE_W-1:0] MODE_HOT_DTR_OFF = 4'h5;
    localparam logic [MODE_W-1:0] MODE_HOT_DTR_ON = 4'h7;
    localparam logic [MODE_W-1:0] MODE_PLAIN_DTR_ON = 4'h6;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int BAUD_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STAT_OFS = 8'h04;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_AUTO_BAUD_SETTING_BIT = 1;
    localparam int CTRL_BAUD_LSB = 4;
    localparam int CTRL_HRATE_LSB = 8;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic CTRL_AUTO_BAUD_SETTING_RST = 1'b0;
    localparam logic [BAUD_W-1:0] CTRL_BAUD_RST = 4'h0;
    localparam logic [BAUD_W-1:0] CTRL_HRATE_RST = 4'h0;
    localparam int STAT_DTR_BIT = 0;
    localparam int STAT_DSR_BIT = 1;
    localparam int STAT_DCD_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_PROMPT_BIT = 4;
    localparam int STAT_LINK_BIT = 5;
    localparam int STAT_STATE_LSB = 8;

endpackage : gw_lead_pkg

// ### hdl/interval_tmr.sv
// Free-running millisecond tick and a reloadable tick countdown
`timescale 1ns/100ps
module interval_tmr #(
    parameter int TICK_CYC = gw_lead_pkg::TICK_CYC
) (
    input wire logic i_mclk,         // System clock
    input wire logic i_rst_n,        // Synchronised reset, active low
    interval_tmr_if.tmr tmr          // Load and expiry
);
    import gw_lead_pkg::*;

    if (TICK_CYC < 2) begin : g_chk
        $error("interval_tmr: TICK_CYC must be at least 2");
    end

    typedef struct packed {
        logic [31:0] div;
        logic tick;
        logic [TMR_W-1:0] count;
        logic expired;
    } tmr_st_t;

    tmr_st_t st_ff;
    tmr_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.div == 32'(TICK_CYC - 1)) begin
            nxt_st.div = 32'h0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.div = st_ff.div + 32'h1;
        end
        // Load wins over a tick in the same cycle
        if (tmr.load) begin
            nxt_st.count = tmr.load_val;
            nxt_st.expired = 1'b0;
        end else if (st_ff.tick && !st_ff.expired) begin
            nxt_st.count = st_ff.count - TMR_W'(1);
            if (st_ff.count <= TMR_W'(1)) begin
                nxt_st.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tmr.expired = st_ff.expired;

endmodule : interval_tmr

// ### hdl/interval_tmr_if.sv
// Carrier between the sequencer and its interval timer
`timescale 1ns/100ps
interface interval_tmr_if;
    import gw_lead_pkg::*;
    logic load;
    logic [TMR_W-1:0] load_val;
    logic expired;
    modport ctl (output load, output load_val, input expired);
    modport tmr (input load, input load_val, output expired);
endinterface : interval_tmr_if

// ### test/gw_dce_model.sv
// Gateway DCE model: carrier follows ring, or dial with DTR on
`timescale 1ns/100ps
module gw_dce_model (
    input wire logic i_mclk, // Clock
    input wire logic i_dtr, // DTR from sequencer
    input wire logic [2:0] i_req, // Ring, dial, DSR drop
    output logic o_dcd = 1'h0, // Carrier detect
    output logic o_dsr = 1'h1 // Data set ready
);
    always @(posedge i_mclk) begin
        o_dcd <= i_req[0] | (i_req[1] & i_dtr);
        o_dsr <= !i_req[2];
    end
endmodule : gw_dce_model

// ### test/testbench.sv
// Self-checking bench for the gateway lead sequencer
`timescale 1ns/100ps
module testbench;
    import gw_lead_pkg::*;
    localparam int TCYC = 2;
    localparam int CW = CARRIER_TICKS * TCYC;
    localparam int HR = HOT_RETRY_TICKS * TCYC;
    logic clk = 1'h0, rst_b = 1'h0, e, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [3:0] mode = 4'h0;
    logic [2:0] g = 3'h0;
    logic [4:0] sw = 5'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q;
    wire [31:0] prdata;
    wire [12:0] ob;
    wire pready, pslverr, dcd, dsr;
    int n, mismatches = 0, check_count = 0;
    assign ob[7] = 1'h0;
    gw_lead_ctrl #(.TICK_CYC(TCYC)) dut (.i_mclk(clk), .i_rst_b(rst_b), .i_mode(mode),
        .i_dsr(dsr), .i_dcd(dcd), .i_out_call(sw[0]), .i_cr_seen(sw[1]), .i_hot_answer(sw[2]),
        .i_hot_noans(sw[3]), .i_local_release(sw[4]), .o_dtr(ob[3]), .o_answer(ob[5]),
        .o_out_busy(ob[2]), .o_prompt_en(ob[6]), .o_link_up(ob[4]), .o_hot_dial(ob[1]),
        .o_hot_baud(ob[11:8]), .o_hot_autobaud(ob[12]), .o_call_drop(ob[0]), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    gw_dce_model gwm (.i_mclk(clk), .i_dtr(ob[3]), .i_req(g), .o_dcd(dcd), .o_dsr(dsr));
    initial forever #12.5 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        check_count++;
        mismatches += int'(got !== exp);
        if (got !== exp) $display("[FAIL] %0t %s: got %h exp %h", $time, s, got, exp);
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk) penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask : apb
    task pulse(input int k);
        @(posedge clk) sw[k] <= 1'h1;
        @(posedge clk) sw[k] <= 1'h0;
        #1;
    endtask : pulse
    task gw(input logic [2:0] v);
        @(posedge clk) g <= v;
    endtask : gw
    task await(input int k, input int lim);
        for (n = 0; n < lim && ob[k] !== 1'h1; n++) @(posedge clk) #1;
    endtask : await
    task rst(input logic [3:0] m);
        @(posedge clk) {mode, rst_b, g} <= {m, 1'h0, 3'h0};
        await(7, 1);
        @(posedge clk) rst_b <= 1'h1;
        await(7, 8);
    endtask : rst
    task give_verdict;
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task t_regs;
        rst(4'h0);
        apb(1'h0, REG_CTRL_OFS, 32'h0);
        chk(q, 32'h1, "ctrl reset");
        apb(1'h1, REG_CTRL_OFS, 32'h933);
        pulse(0);
        chk(ob[7:0], 32'h0, "inactive mode");
        apb(1'h1, 8'h08, 32'hffff_ffff);
        chk(e, 32'h1, "unmapped");
        apb(1'h0, REG_CTRL_OFS, 32'h0);
        chk(q, 32'h933, "ctrl kept");
        apb(1'h0, REG_STAT_OFS, 32'h0);
        chk(q, 32'h2, "status idle");
        @(posedge clk) mode <= MODE_HOT_DTR_OFF;
        await(7, 6);
        chk(ob[12:8], 32'h13, "mode 5 rate");
        @(posedge clk) mode <= MODE_HOT_DTR_ON;
        await(7, 6);
        chk(ob[12:8], 32'h09, "mode 7 rate");
        $display("Test regs done");
    endtask : t_regs
    task t_out;
        rst(MODE_GW_LO);
        pulse(0);
        chk(ob[6:3], 32'h7, "answer");
        gw(3'h2);
        await(7, 8);
        gw(3'h6);
        await(0, 20);
        chk(ob[4:0], 32'h1, "dsr drop");
        gw(3'h0);
        pulse(0);
        await(0, CW + 20);
        chk({n >= CW - 6 && n <= CW + 6, ob[3]}, 32'h2, "no carrier");
        $display("Test outbound done");
    endtask : t_out
    task t_in;
        rst(MODE_PLAIN_DTR_ON);
        chk(ob[3], 32'h1, "idle dtr");
        gw(3'h1);
        await(2, 20);
        chk({ob[6], ob[4], ob[2]}, 32'h5, "in busy");
        apb(1'h0, REG_STAT_OFS, 32'h0);
        chk(q, 32'h21f, "status in");
        pulse(1);
        chk(ob[4], 32'h1, "in link");
        gw(3'h0);
        await(0, 20);
        await(7, DTR_DROP_TICKS * TCYC - 8);
        chk(ob[3], 32'h0, "dtr off");
        await(3, 20);
        chk(ob[3], 32'h1, "dtr back");
        $display("Test inbound done");
    endtask : t_in
    task t_hot;
        rst(MODE_HOT_DTR_OFF);
        gw(3'h1);
        await(1, 20);
        chk(ob[1], 32'h1, "hot dial");
        pulse(3);
        await(1, HR + 20);
        chk(n >= HR - 6 && n <= HR + 6, 32'h1, "retry gap");
        pulse(2);
        chk(ob[4], 32'h1, "hot link");
        pulse(4);
        chk({ob[3], ob[0]}, 32'h1, "release");
        $display("Test hotline done");
    endtask : t_hot
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        t_regs();
        t_out();
        t_in();
        t_hot();
        give_verdict();
    end
endmodule : testbench
